/* inc/stcu_pkg.sv */
// Purpose: constants shared by the time constant update block
// Assumes: 32-bit register words, byte addresses on a 6-bit bus
// Notes: flag bit positions follow the axis status word layout
package stcu_pkg;
  localparam logic [15:0] STCU_CMD_IDLE = 16'h0000;
  localparam logic [15:0] STCU_CMD_DECEL = 16'h000B;
  localparam logic [15:0] STCU_CMD_FILT = 16'h000C;
  localparam logic [5:0] STCU_OFF_CMD = 6'h00;
  localparam logic [5:0] STCU_OFF_CTRL = 6'h04;
  localparam logic [5:0] STCU_OFF_DECEL = 6'h08;
  localparam logic [5:0] STCU_OFF_SCURVE = 6'h0C;
  localparam logic [5:0] STCU_OFF_RESP = 6'h10;
  localparam logic [5:0] STCU_OFF_FLAGS = 6'h14;
  localparam logic [5:0] STCU_OFF_WARN = 6'h18;
  localparam logic [5:0] STCU_OFF_ALARM = 6'h1C;
  localparam logic [5:0] STCU_OFF_IRQ_ST = 6'h20;
  localparam logic [5:0] STCU_OFF_IRQ_MASK = 6'h24;
  localparam logic [5:0] STCU_OFF_DECEL_ACT = 6'h28;
  localparam logic [5:0] STCU_OFF_SCURVE_ACT = 6'h2C;
  localparam int STCU_CTRL_PAUSE = 0;
  localparam int STCU_CTRL_ABORT = 1;
  localparam int STCU_FL_EXEC = 0;
  localparam int STCU_FL_HOLD = 1;
  localparam int STCU_FL_ERR = 3;
  localparam int STCU_FL_DONE = 8;
  localparam int STCU_FL_DIST = 12;
  localparam int STCU_IRQ_W = 3;
  localparam int STCU_IRQ_DONE = 0;
  localparam int STCU_IRQ_ERR = 1;
  localparam int STCU_IRQ_ALARM = 2;
  localparam logic [31:0] STCU_RST_DECEL = 32'h0000_0000;
  localparam logic [15:0] STCU_RST_SCURVE = 16'h0000;
  typedef enum logic [1:0] {
    STCU_ST_IDLE = 2'b00,
    STCU_ST_SEND = 2'b01,
    STCU_ST_FAULT = 2'b11,
    STCU_ST_HOLD = 2'b10
  } stcu_state_e;
endpackage

/* logic/stcu_irq.sv */
// Purpose: sticky event bits, mask and one level interrupt
// Assumes: events are one-cycle pulses on clk_sys
// Notes: a one written to a status bit clears it
`timescale 1ns/10ps
module stcu_irq #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Events
  input wire logic [W-1:0] event_in,
  // Software access
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [W-1:0] wr_data,
  // State
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] clr_bits;

  assign clr_bits = clr_wr ? wr_data : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_bits) | event_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mask <= '0;
    end else if (mask_wr) begin
      mask <= wr_data;
    end
  end

  assign irq = |(status & mask);
endmodule

/* logic/stcu_drv_link.sv */
// Purpose: one parameter write toward the drive, held until answered
// Assumes: the network front end runs on clk_sys
// Notes: a new start while busy is ignored
`timescale 1ns/10ps
module stcu_drv_link (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Request from the command sequencer
  input wire logic start,
  input wire logic sel_in,
  input wire logic [31:0] data_in,
  output logic done,
  output logic fail,
  // Toward the drive
  output logic drv_req,
  output logic drv_sel,
  output logic [31:0] drv_data,
  input wire logic drv_ack,
  input wire logic drv_err
);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drv_req <= 1'b0;
      drv_sel <= 1'b0;
      drv_data <= 32'h0000_0000;
    end else if (!drv_req && start) begin
      drv_req <= 1'b1;
      drv_sel <= sel_in;
      drv_data <= data_in;
    end else if (drv_req && drv_ack) begin
      drv_req <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= drv_req && drv_ack;
      fail <= drv_req && drv_ack && drv_err;
    end
  end
endmodule

/* logic/stcu_top.sv */
// Purpose: deceleration and filter-time update commands of one axis
// Assumes: register port and drive front end share clk_sys
// Notes: an update code starts work only once the idle command has been seen since the last start
`timescale 1ns/10ps
module stcu_top
  import stcu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Drive parameter link
  output logic drv_req,
  output logic drv_sel,
  output logic [31:0] drv_data,
  input wire logic drv_ack,
  input wire logic drv_err,
  // Drive monitor codes
  input wire logic [31:0] warn_code,
  input wire logic warn_load,
  input wire logic [31:0] alarm_code,
  input wire logic alarm_load,
  // Motion generator state
  input wire logic distribution_done_flag,
  // Axis status
  output logic [15:0] command_response_word,
  output logic command_executing_flag,
  output logic hold_completed_flag,
  output logic error_end_flag,
  output logic execution_completed_flag,
  // Interrupt
  output logic irq
);
  stcu_state_e state_reg;
  stcu_state_e state_next;
  logic [15:0] motion_command_word;
  logic pause_request_bit;
  logic abort_request_bit;
  logic [31:0] deceleration_time_setting;
  logic [15:0] s_curve_time_setting;
  logic [31:0] warning_monitor_word;
  logic [31:0] alarm_monitor_word;
  logic [31:0] decel_applied_reg;
  logic [15:0] scurve_applied_reg;
  logic [15:0] resp_reg;
  logic exec_reg;
  logic err_reg;
  logic done_reg;
  logic arm_reg;
  logic sel_reg;
  logic [31:0] rdata_reg;
  logic wr_cmd;
  logic is_update;
  logic start;
  logic fault;
  logic link_start;
  logic link_done;
  logic link_fail;
  logic [STCU_IRQ_W-1:0] irq_events;
  logic [STCU_IRQ_W-1:0] irq_status;
  logic [STCU_IRQ_W-1:0] irq_mask;
  logic [31:0] flags_word;

  assign wr_cmd = reg_wr && (reg_addr == STCU_OFF_CMD);
  assign is_update = (motion_command_word == STCU_CMD_DECEL) ||
                     (motion_command_word == STCU_CMD_FILT);

  // Start needs a prior idle command, so a code left in place never reruns
  assign start = (state_reg == STCU_ST_IDLE) && arm_reg && is_update;

  // The preconditions are the host's duty; a violation still ends in error
  assign fault = (warning_monitor_word != 32'h0000_0000) ||
                 (alarm_monitor_word != 32'h0000_0000) ||
                 !distribution_done_flag;

  assign link_start = start && !fault;

  // Command word and setting registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      motion_command_word <= STCU_CMD_IDLE;
    end else if (wr_cmd) begin
      motion_command_word <= reg_wdata[15:0];
    end
  end

  // Pause and abort are stored for read-back only; nothing here acts on them
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pause_request_bit <= 1'b0;
      abort_request_bit <= 1'b0;
    end else if (reg_wr && (reg_addr == STCU_OFF_CTRL)) begin
      pause_request_bit <= reg_wdata[STCU_CTRL_PAUSE];
      abort_request_bit <= reg_wdata[STCU_CTRL_ABORT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      deceleration_time_setting <= STCU_RST_DECEL;
    end else if (reg_wr && (reg_addr == STCU_OFF_DECEL)) begin
      deceleration_time_setting <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_curve_time_setting <= STCU_RST_SCURVE;
    end else if (reg_wr && (reg_addr == STCU_OFF_SCURVE)) begin
      s_curve_time_setting <= reg_wdata[15:0];
    end
  end

  // Arming follows the command word as stored by a write in an earlier cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      arm_reg <= 1'b0;
    end else if (start) begin
      arm_reg <= 1'b0;
    end else if (motion_command_word == STCU_CMD_IDLE) begin
      arm_reg <= 1'b1;
    end
  end

  // Monitor words keep the most recent codes from the drive
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      warning_monitor_word <= 32'h0000_0000;
    end else if (warn_load) begin
      warning_monitor_word <= warn_code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      alarm_monitor_word <= 32'h0000_0000;
    end else if (alarm_load) begin
      alarm_monitor_word <= alarm_code;
    end
  end

  // Command sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      STCU_ST_IDLE: begin
        if (start && fault) begin
          state_next = STCU_ST_FAULT;
        end else if (start) begin
          state_next = STCU_ST_SEND;
        end
      end
      STCU_ST_SEND: begin
        // Neither pause nor abort can cut the transfer short
        if (link_done) begin
          state_next = STCU_ST_HOLD;
        end
      end
      STCU_ST_FAULT: begin
        state_next = STCU_ST_HOLD;
      end
      STCU_ST_HOLD: begin
        if (motion_command_word == STCU_CMD_IDLE) begin
          state_next = STCU_ST_IDLE;
        end
      end
      default: begin
        state_next = STCU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= STCU_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remember which setting goes out, for the applied copy on success
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sel_reg <= 1'b0;
    end else if (start) begin
      sel_reg <= (motion_command_word == STCU_CMD_FILT);
    end
  end

  // Response word names the running command until the idle command
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      resp_reg <= STCU_CMD_IDLE;
    end else if (start) begin
      resp_reg <= motion_command_word;
    end else if ((state_reg == STCU_ST_HOLD) &&
                 (motion_command_word == STCU_CMD_IDLE)) begin
      resp_reg <= STCU_CMD_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      exec_reg <= 1'b0;
    end else if (start) begin
      exec_reg <= 1'b1;
    end else if (link_done || (state_reg == STCU_ST_FAULT)) begin
      exec_reg <= 1'b0;
    end
  end

  // Error end survives the idle command and clears only on a new start
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      err_reg <= 1'b0;
    end else if (start) begin
      err_reg <= 1'b0;
    end else if (link_fail || (state_reg == STCU_ST_FAULT)) begin
      err_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else if (start) begin
      done_reg <= 1'b0;
    end else if (link_done && !link_fail) begin
      done_reg <= 1'b1;
    end else if ((state_reg == STCU_ST_HOLD) &&
                 (motion_command_word == STCU_CMD_IDLE)) begin
      done_reg <= 1'b0;
    end
  end

  // Copies of what the drive has accepted
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      decel_applied_reg <= STCU_RST_DECEL;
    end else if (link_done && !link_fail && !sel_reg) begin
      decel_applied_reg <= drv_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scurve_applied_reg <= STCU_RST_SCURVE;
    end else if (link_done && !link_fail && sel_reg) begin
      scurve_applied_reg <= drv_data[15:0];
    end
  end

  // Code 11 sends the deceleration time, code 12 the S-curve time
  stcu_drv_link u_link (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(link_start),
    .sel_in(motion_command_word == STCU_CMD_FILT),
    .data_in((motion_command_word == STCU_CMD_FILT) ?
             {16'h0000, s_curve_time_setting} :
             deceleration_time_setting),
    .done(link_done),
    .fail(link_fail),
    .drv_req(drv_req),
    .drv_sel(drv_sel),
    .drv_data(drv_data),
    .drv_ack(drv_ack),
    .drv_err(drv_err)
  );

  // Interrupt events
  always_comb begin
    irq_events = '0;
    irq_events[STCU_IRQ_DONE] = link_done && !link_fail;
    irq_events[STCU_IRQ_ERR] = link_fail || (state_reg == STCU_ST_FAULT);
    irq_events[STCU_IRQ_ALARM] = alarm_load &&
                                 (alarm_code != 32'h0000_0000);
  end

  stcu_irq #(
    .W(STCU_IRQ_W)
  ) u_irq (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .event_in(irq_events),
    .clr_wr(reg_wr && (reg_addr == STCU_OFF_IRQ_ST)),
    .mask_wr(reg_wr && (reg_addr == STCU_OFF_IRQ_MASK)),
    .wr_data(reg_wdata[STCU_IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // Status word seen by software
  always_comb begin
    flags_word = 32'h0000_0000;
    flags_word[STCU_FL_EXEC] = exec_reg;
    flags_word[STCU_FL_HOLD] = 1'b0;
    flags_word[STCU_FL_ERR] = err_reg;
    flags_word[STCU_FL_DONE] = done_reg;
    flags_word[STCU_FL_DIST] = distribution_done_flag;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        STCU_OFF_CMD: rdata_reg <= {16'h0000, motion_command_word};
        STCU_OFF_CTRL: begin
          rdata_reg <= {30'h0, abort_request_bit,
                        pause_request_bit};
        end
        STCU_OFF_DECEL: rdata_reg <= deceleration_time_setting;
        STCU_OFF_SCURVE: rdata_reg <= {16'h0000, s_curve_time_setting};
        STCU_OFF_RESP: rdata_reg <= {16'h0000, resp_reg};
        STCU_OFF_FLAGS: rdata_reg <= flags_word;
        STCU_OFF_WARN: rdata_reg <= warning_monitor_word;
        STCU_OFF_ALARM: rdata_reg <= alarm_monitor_word;
        STCU_OFF_IRQ_ST: begin
          rdata_reg <= {{(32-STCU_IRQ_W){1'b0}}, irq_status};
        end
        STCU_OFF_IRQ_MASK: begin
          rdata_reg <= {{(32-STCU_IRQ_W){1'b0}}, irq_mask};
        end
        STCU_OFF_DECEL_ACT: rdata_reg <= decel_applied_reg;
        STCU_OFF_SCURVE_ACT: rdata_reg <= {16'h0000, scurve_applied_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign command_response_word = resp_reg;
  assign command_executing_flag = exec_reg;
  assign hold_completed_flag = 1'b0;
  assign error_end_flag = err_reg;
  assign execution_completed_flag = done_reg;
endmodule

/* verif/stcu_top_properties.sv */
// Purpose: port-level checks of the update command block
// Assumes: one clock, synchronous active-low reset
// Notes: watches the drive link and status outputs only
`timescale 1ns/10ps
module stcu_top_props
  import stcu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Drive link
  input wire logic drv_req,
  input wire logic drv_sel,
  input wire logic drv_ack,
  input wire logic drv_err,
  // Axis status
  input wire logic [15:0] command_response_word,
  input wire logic command_executing_flag,
  input wire logic hold_completed_flag,
  input wire logic error_end_flag,
  input wire logic execution_completed_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_hold_never_on: assert property (!hold_completed_flag)
    else $error("hold completed flag raised");
  a_req_held: assert property (drv_req && !drv_ack |=>
    drv_req && $stable(drv_sel))
    else $error("drive request dropped before answer");
  a_req_released: assert property (drv_req && drv_ack |=> !drv_req)
    else $error("drive request kept after answer");
  a_exec_covers_req: assert property (drv_req |->
    command_executing_flag)
    else $error("request outside executing");
  a_exec_ends: assert property (drv_req && drv_ack |=>
    command_executing_flag ##1 !command_executing_flag)
    else $error("executing flag timing wrong");
  a_done_sets: assert property (drv_req && drv_ack && !drv_err |=>
    ##1 execution_completed_flag && !error_end_flag)
    else $error("completed flag missing");
  a_error_sets: assert property (drv_req && drv_ack && drv_err |=>
    ##1 error_end_flag && !execution_completed_flag)
    else $error("error end flag missing");
  a_decel_code: assert property (drv_req && !drv_sel |->
    command_response_word == STCU_CMD_DECEL)
    else $error("wrong response in deceleration update");
  a_filt_code: assert property (drv_req && drv_sel |->
    command_response_word == STCU_CMD_FILT)
    else $error("wrong response in filter-time update");
  a_error_kept: assert property ($fell(error_end_flag) |->
    $rose(command_executing_flag))
    else $error("error end cleared without new command");
  a_start_clean: assert property ($rose(command_executing_flag) |->
    !error_end_flag && !execution_completed_flag)
    else $error("stale end flags at start");
endmodule

bind stcu_top stcu_top_props i_stcu_top_props (.clk_sys, .rst_b,
  .drv_req, .drv_sel, .drv_ack, .drv_err, .command_response_word,
  .command_executing_flag, .hold_completed_flag, .error_end_flag,
  .execution_completed_flag);

/* verif/stcu_drive_model.sv */
// Purpose: networked servo drive answering parameter writes
// Assumes: request held until answered, same clock
// Notes: delay and failure are set by the bench per transfer
`timescale 1ns/10ps
module stcu_drive_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Behaviour
  input wire logic [3:0] ack_delay,
  input wire logic fail_next,
  // Link
  input wire logic drv_req,
  input wire logic drv_sel,
  input wire logic [31:0] drv_data,
  output logic drv_ack,
  output logic drv_err,
  // Accepted constants
  output logic [31:0] decel_const,
  output logic [15:0] avg_time
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drv_ack <= 1'b0;
      drv_err <= 1'b0;
      wait_cnt <= 4'h0;
      decel_const <= 32'h0;
      avg_time <= 16'h0;
    end else begin
      drv_ack <= 1'b0;
      // Error line means nothing without ack, so it wanders
      drv_err <= ~drv_err;
      if (drv_req && !drv_ack) begin
        if (wait_cnt == ack_delay) begin
          drv_ack <= 1'b1;
          drv_err <= fail_next;
          wait_cnt <= 4'h0;
          if (!fail_next && !drv_sel) begin
            // This drive does have a deceleration constant to write
            decel_const <= drv_data;
          end
          if (!fail_next && drv_sel) begin
            avg_time <= drv_data[15:0];
          end
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench of the time constant update block
// Assumes: master strobes change just after rising edges
// Notes: table rows run each command, pass and fail
`timescale 1ns/10ps
module testbench
  import stcu_pkg::*;
;
  typedef struct packed {
    logic [15:0] cmd;
    logic fail;
    logic [31:0] val;
    logic [31:0] flags;
  } stcu_row_s;
  logic clk_sys, rst_b, reg_wr, reg_rd, drv_req, drv_sel, drv_ack;
  logic drv_err, warn_load, alarm_load, distribution_done_flag, irq;
  logic command_executing_flag, hold_completed_flag, error_end_flag;
  logic execution_completed_flag, fail_next;
  logic [5:0] reg_addr;
  logic [3:0] ack_delay;
  logic [15:0] command_response_word, avg_time;
  logic [31:0] reg_wdata, reg_rdata, drv_data, warn_code, alarm_code;
  logic [31:0] decel_const;
  int err_total, cmp_count;
  stcu_row_s rows [4] = '{
    '{16'h000B, 1'b0, 32'h0001_2345, 32'h0000_1100},
    '{16'h000C, 1'b0, 32'h0000_0ABC, 32'h0000_1100},
    '{16'h000B, 1'b1, 32'h0000_7777, 32'h0000_1008},
    '{16'h000C, 1'b1, 32'h0000_0123, 32'h0000_1008}};

  stcu_top i_stcu_top (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .drv_req, .drv_sel, .drv_data, .drv_ack,
    .drv_err, .warn_code, .warn_load, .alarm_code, .alarm_load,
    .distribution_done_flag, .command_response_word,
    .command_executing_flag, .hold_completed_flag, .error_end_flag,
    .execution_completed_flag, .irq);
  stcu_drive_model i_stcu_drive_model (.clk_sys, .rst_b, .ack_delay,
    .fail_next, .drv_req, .drv_sel, .drv_data, .drv_ack, .drv_err,
    .decel_const, .avg_time);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic run_cmd(input logic [15:0] c);
    wr(STCU_OFF_CMD, {16'h0, c});
    @(posedge clk_sys);
    #1 check({29'h0, command_executing_flag, error_end_flag,
      execution_completed_flag}, 32'h4);
    check({16'h0, command_response_word}, {16'h0, c});
  endtask
  task automatic wait_done();
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      if (command_executing_flag === 1'b0) break;
    end
    check({31'h0, command_executing_flag}, 32'h0);
  endtask
  task automatic load_mon(input logic [31:0] w, input logic [31:0] a);
    @(posedge clk_sys);
    warn_code <= w;
    alarm_code <= a;
    warn_load <= 1'b1;
    alarm_load <= 1'b1;
    @(posedge clk_sys);
    warn_load <= 1'b0;
    alarm_load <= 1'b0;
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles; this allows 20000 cycles, many times that
  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h0;
    reg_wdata = 32'h0;
    warn_code = 32'h0;
    alarm_code = 32'h0;
    warn_load = 1'b0;
    alarm_load = 1'b0;
    distribution_done_flag = 1'b1;
    ack_delay = 4'h0;
    fail_next = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(STCU_OFF_FLAGS, 32'h0000_1000);
    rd_chk(STCU_OFF_DECEL, STCU_RST_DECEL);
    rd_chk(6'h3C, 32'h0);
    rd_chk(STCU_OFF_WARN, 32'h0);
    rd_chk(STCU_OFF_ALARM, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ack_delay <= 4'(3 * i);
      fail_next <= rows[i].fail;
      wr(STCU_OFF_IRQ_MASK, i[0] ? 32'h0 : 32'h7);
      wr(STCU_OFF_DECEL, rows[i].val);
      wr(STCU_OFF_SCURVE, {16'h0, rows[i].val[15:0]});
      rd_chk(STCU_OFF_RESP, 32'h0);
      if (rows[i].cmd == STCU_CMD_FILT) begin
        wr(STCU_OFF_CMD, 32'h0000_000D);
        wr(STCU_OFF_CMD, 32'h0);
      end
      // Every update is issued by hand through the command word
      run_cmd(rows[i].cmd);
      wait_done();
      rd_chk(STCU_OFF_FLAGS, rows[i].flags);
      check({31'h0, irq}, {31'h0, !i[0]});
      if (!rows[i].fail && rows[i].cmd == STCU_CMD_DECEL) begin
        check(decel_const, rows[i].val);
      end
      if (!rows[i].fail && rows[i].cmd == STCU_CMD_FILT) begin
        check({16'h0, avg_time}, {16'h0, rows[i].val[15:0]});
      end
      wr(STCU_OFF_IRQ_ST, 32'h7);
      rd_chk(STCU_OFF_IRQ_ST, 32'h0);
      wr(STCU_OFF_CMD, 32'h0);
      rd_chk(STCU_OFF_RESP, 32'h0);
      rd_chk(STCU_OFF_FLAGS, rows[i].flags & 32'hFFFF_FEFF);
    end
    // Slow drive, pause and abort written mid-command
    ack_delay <= 4'hC;
    fail_next <= 1'b0;
    wr(STCU_OFF_SCURVE, 32'h0000_0055);
    run_cmd(STCU_CMD_FILT);
    wr(STCU_OFF_CTRL, 32'h3);
    wait_done();
    rd_chk(STCU_OFF_FLAGS, 32'h0000_1100);
    check({16'h0, avg_time}, 32'h0000_0055);
    rd_chk(STCU_OFF_CTRL, 32'h0000_0003);
    rd_chk(STCU_OFF_SCURVE_ACT, 32'h0000_0055);
    rd_chk(STCU_OFF_DECEL_ACT, 32'h0001_2345);
    // Same code again without the idle command must not start
    wr(STCU_OFF_CMD, {16'h0, STCU_CMD_FILT});
    repeat (3) @(posedge clk_sys);
    #1 check({31'h0, command_executing_flag}, 32'h0);
    wr(STCU_OFF_CTRL, 32'h0);
    wr(STCU_OFF_CMD, 32'h0);
    wr(STCU_OFF_IRQ_ST, 32'h7);
    // Alarm present at start ends in error with no drive write
    load_mon(32'h0000_005A, 32'h0000_00A5);
    rd_chk(STCU_OFF_WARN, 32'h0000_005A);
    rd_chk(STCU_OFF_ALARM, 32'h0000_00A5);
    wr(STCU_OFF_DECEL, 32'h0000_0999);
    run_cmd(STCU_CMD_DECEL);
    wait_done();
    rd_chk(STCU_OFF_FLAGS, 32'h0000_1008);
    check(decel_const, 32'h0001_2345);
    rd_chk(STCU_OFF_IRQ_ST, 32'h6);
    load_mon(32'h0, 32'h0);
    wr(STCU_OFF_CMD, 32'h0);
    // Distribution not done also ends in error
    distribution_done_flag <= 1'b0;
    run_cmd(STCU_CMD_DECEL);
    wait_done();
    rd_chk(STCU_OFF_FLAGS, 32'h0000_0008);
    check(decel_const, 32'h0001_2345);
    // Reset in mid-transfer drops the request and every status flag
    distribution_done_flag <= 1'b1;
    wr(STCU_OFF_CMD, 32'h0);
    ack_delay <= 4'hF;
    run_cmd(STCU_CMD_DECEL);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1 check({28'h0, drv_req, command_executing_flag, error_end_flag,
      execution_completed_flag}, 32'h0);
    check({16'h0, command_response_word}, 32'h0);
    rd_chk(STCU_OFF_FLAGS, 32'h0000_1000);
    rd_chk(STCU_OFF_CMD, 32'h0);
    complete_run();
  end
endmodule
